// ==== common/eeprom_front_pkg.sv ====
// constants and types for the two-wire memory front end
package eeprom_front_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 32'h0000_0019;
    localparam int PROG_TIME_NS = 32'h004C_4B40;
    // longest time: round down
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int NOISE_TIME_NS = 32'h0000_0032;
    // least time: round up
    localparam int FILT_CYCLES = (NOISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // fastest grade low phase, bounds sampling latency
    localparam int SCL_LOW_MIN_NS = 32'h0000_01F4;
    localparam int SCL_LOW_CYCLES = SCL_LOW_MIN_NS / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // array and bus layout
    // ----------------------------------------------------------------
    localparam int MEM_DEPTH = 32'h0000_0100;
    localparam int PAGE_BYTES = 32'h0000_0008;
    localparam int WR_FIFO_DEPTH = 32'h0000_0002;
    localparam logic [3:0] CTRL_CODE = 4'hA;
    localparam int GUARD_ADDR_BIT = 32'h0000_0007;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_DONE = 4'h8;
    localparam logic [5:0] SYNC_RESET = 6'h03;

    typedef struct packed {
        logic [2:0] offset;
        logic keep;
        logic [7:0] data;
    } wr_item_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_RACK = 5'h10
    } link_state_type;

    typedef enum logic [1:0] {
        KIND_DEV = 2'h0,
        KIND_WORD = 2'h1,
        KIND_DATA = 2'h2
    } byte_kind_type;
endpackage : eeprom_front_pkg

// ==== verif/tb.sv ====
// self-checking bench for the two-wire memory front end
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb;
    localparam int PROG = 400;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap_r = 3'b000;
    logic [2:0] sel = 3'b000;
    logic guard_r = 1'b0;
    tri0 [2:0] strap_w;
    tri0 guard_w;
    wire scl_w;
    wire sda_w;
    wire host_low;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic oe_q = 1'b0;
    logic scl_q = 1'b1;
    int errors = 0;
    int samples_checked = 0;

    assign strap_w = strap_r;
    assign guard_w = guard_r;
    assign sda_w = ~(host_low | (sda_oe & ~sda_out));

    always #12.5 clk_sys = ~clk_sys;

    eeprom_twowire_front #(.PROG_CYCLES(PROG)) dut_u (
        .CLK_SYS_IN(clk_sys), .RST_IN(rst), .SCL_IN(scl_w), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .SELECT_STRAP_0_IN(strap_w[0]),
        .SELECT_STRAP_1_IN(strap_w[1]), .SELECT_STRAP_2_IN(strap_w[2]),
        .WRITE_GUARD_IN(guard_w), .BUSY_OUT(busy));

    twowire_host_model #(.PHASE(8)) host_u (
        .clk_in(clk_sys), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(host_low));

    // data drive may only move while the clock is low
    always @(posedge clk_sys) begin
        oe_q <= sda_oe;
        scl_q <= scl_w;
        if (!rst && sda_oe !== oe_q && scl_w && scl_q) begin
            `CHK(1'b0, 1'b1)
        end
    end

    task automatic results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic wait_prog(input logic exp_busy);
        int cnt;
        cnt = 0;
        for (int i = 0; i < 40 && busy !== 1'b1; i++) begin
            @(posedge clk_sys);
        end
        `CHK(busy, exp_busy)
        while (busy === 1'b1 && cnt <= PROG + 1) begin
            @(posedge clk_sys);
            cnt++;
        end
        `CHK(cnt <= PROG + 1, 1'b1)
        if (busy === 1'b1) results();
    endtask : wait_prog

    task automatic set_straps(input logic [2:0] s);
        @(posedge clk_sys);
        strap_r <= s;
        repeat (10) @(posedge clk_sys);
    endtask : set_straps

    task automatic probe(input logic [2:0] s, input logic exp);
        logic ack;
        host_u.start_cond();
        host_u.send_byte({eeprom_front_pkg::CTRL_CODE, s, 1'b0}, ack);
        `CHK(ack, exp)
        host_u.stop_cond();
    endtask : probe

    task automatic write_seq(input logic [7:0] addr, input logic [7:0] base, input int n);
        logic ack;
        host_u.start_cond();
        host_u.send_byte({eeprom_front_pkg::CTRL_CODE, sel, 1'b0}, ack);
        `CHK(ack, 1'b1)
        host_u.send_byte(addr, ack);
        `CHK(ack, 1'b1)
        for (int k = 0; k < n; k++) begin
            host_u.send_byte(base + 8'(k), ack);
            `CHK(ack, 1'b1)
        end
        host_u.stop_cond();
    endtask : write_seq

    task automatic read_pair(input logic [7:0] addr, input logic [7:0] e0,
                             input logic [7:0] e1);
        logic ack;
        logic [7:0] d;
        host_u.start_cond();
        host_u.send_byte({eeprom_front_pkg::CTRL_CODE, sel, 1'b0}, ack);
        host_u.send_byte(addr, ack);
        host_u.start_cond();
        host_u.send_byte({eeprom_front_pkg::CTRL_CODE, sel, 1'b1}, ack);
        `CHK(ack, 1'b1)
        host_u.recv_byte(1'b1, d);
        `CHK(d, e0)
        host_u.recv_byte(1'b0, d);
        `CHK(d, e1)
        `CHK(sda_out, 1'b0)
        host_u.stop_cond();
    endtask : read_pair

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_write_read();
        sel = 3'b101;
        set_straps(3'b101);
        write_seq(8'h12, 8'h5A, 2);
        wait_prog(1'b1);
        read_pair(8'h12, 8'h5A, 8'h5B);
    endtask : sc_write_read

    task automatic sc_page();
        write_seq(8'h3F, 8'h30, 3);
        probe(sel, 1'b0);
        wait_prog(1'b1);
        read_pair(8'h38, 8'h31, 8'h32);
    endtask : sc_page

    task automatic sc_select();
        for (int s = 0; s < 8; s++) begin
            set_straps(3'(s));
            probe(3'(s), 1'b1);
            probe(3'(s) ^ 3'b010, 1'b0);
        end
        set_straps(3'bzzz);
        probe(3'b000, 1'b1);
        sel = 3'b000;
    endtask : sc_select

    task automatic sc_guard();
        write_seq(8'h90, 8'h77, 1);
        wait_prog(1'b1);
        guard_r <= 1'b1;
        write_seq(8'h90, 8'hEE, 1);
        wait_prog(1'b0);
        write_seq(8'h10, 8'h22, 2);
        wait_prog(1'b1);
        guard_r <= 1'bz;
        write_seq(8'h91, 8'h44, 1);
        wait_prog(1'b1);
        read_pair(8'h90, 8'h77, 8'h44);
        read_pair(8'h10, 8'h22, 8'h23);
    endtask : sc_guard

    task automatic sc_glitch();
        host_u.glitch_en = 1'b1;
        write_seq(8'h20, 8'hA5, 2);
        wait_prog(1'b1);
        read_pair(8'h20, 8'hA5, 8'hA6);
        host_u.glitch_en = 1'b0;
    endtask : sc_glitch

    initial begin
        repeat (16) @(posedge clk_sys);
        `CHK(busy, 1'b0)
        `CHK(sda_oe, 1'b0)
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        sc_write_read();
        sc_page();
        sc_select();
        sc_guard();
        sc_glitch();
        results();
    end
endmodule : tb

// ==== verif/twowire_host_model.sv ====
// bus host model that clocks bytes into and out of the memory front end
`timescale 1ns/1ps
module twowire_host_model #(
    parameter int PHASE = 8
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    logic glitch_en = 1'b0;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // also serves as repeated start
    task automatic start_cond();
        @(posedge clk_in) sda_low_out <= 1'b0;
        tick(PHASE / 2);
        scl_out <= 1'b1;
        tick(PHASE);
        sda_low_out <= 1'b1;
        tick(PHASE);
        scl_out <= 1'b0;
        tick(PHASE / 2);
    endtask : start_cond

    task automatic stop_cond();
        @(posedge clk_in) sda_low_out <= 1'b1;
        tick(PHASE / 2);
        scl_out <= 1'b1;
        tick(PHASE);
        sda_low_out <= 1'b0;
        tick(PHASE);
    endtask : stop_cond

    // short clock pulse in the low phase must be filtered away
    task automatic clock_bit(input logic b, output logic got);
        @(posedge clk_in) sda_low_out <= ~b;
        if (glitch_en) begin
            tick(1);
            scl_out <= 1'b1;
            tick(1);
            scl_out <= 1'b0;
        end
        tick(PHASE / 2);
        scl_out <= 1'b1;
        tick(PHASE);
        got = sda_in;
        scl_out <= 1'b0;
        tick(PHASE / 2 - 1);
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], got);
        end
        clock_bit(1'b1, got);
        ack = ~got;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(~ack, got);
    endtask : recv_byte
endmodule : twowire_host_model

// ==== verilog/eeprom_twowire_front.sv ====
// two-wire serial slave front end with 256-byte array and page programming
// Summary of operation
// - the array holds 256 bytes addressed by one byte-wide word address.
// - page writes take up to 8 bytes within one page, fewer also program.
// - after a write ends a self-timed programming cycle of at most 5 ms runs.
// - random reads from a chosen address and sequential reads are served.
// - the device answers only when the select bits match its three straps.
// - undriven strap or guard inputs count as low.
// - incoming bits are sampled on each rising serial clock edge.
// - outgoing data changes only after a falling serial clock edge.
// - the data line is driven open-drain, low or released.
// - with the guard high, writes to the upper half are inhibited.
// - with the guard low, every location may be written.
// - bus clocks up to 100 kHz, 400 kHz and 1 MHz are served.
// - clock and data inputs are filtered so short glitches are ignored.
`timescale 1ns/1ps
module eeprom_twowire_front #(
    parameter int PROG_CYCLES = eeprom_front_pkg::PROG_CYCLES,
    parameter int FILT_CYCLES = eeprom_front_pkg::FILT_CYCLES,
    parameter int FIFO_DEPTH = eeprom_front_pkg::WR_FIFO_DEPTH
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic SELECT_STRAP_0_IN,
    input wire logic SELECT_STRAP_1_IN,
    input wire logic SELECT_STRAP_2_IN,
    input wire logic WRITE_GUARD_IN,
    output logic BUSY_OUT
);
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam int FPW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int FCW = $clog2(FIFO_DEPTH + 1);

    if (PROG_CYCLES < 1 || FIFO_DEPTH < 2 || FILT_CYCLES < 1 || FILT_CYCLES > 255
        || FILT_CYCLES + 5 >= eeprom_front_pkg::SCL_LOW_CYCLES) begin : g_bad_param
        $error("unsupported parameter value");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            meta_r <= eeprom_front_pkg::SYNC_RESET;
            sync_r <= eeprom_front_pkg::SYNC_RESET;
        end else begin
            meta_r <= {WRITE_GUARD_IN, SELECT_STRAP_2_IN, SELECT_STRAP_1_IN,
                       SELECT_STRAP_0_IN, SDA_IN, SCL_IN};
            sync_r <= meta_r;
        end
    end
    logic [2:0] strap;
    logic guard;
    assign strap = sync_r[4:2];
    assign guard = sync_r[5];

    // ----------------------------------------------------------------
    // glitch filters for clock and data
    // ----------------------------------------------------------------
    logic [1:0] line_f;
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic [7:0] cnt_r, cnt_nxt;
        logic lvl_r, lvl_nxt;
        always_comb begin
            cnt_nxt = cnt_r;
            lvl_nxt = lvl_r;
            if (sync_r[g] == lvl_r) begin
                cnt_nxt = 8'h00;
            end else if (cnt_r == 8'(FILT_CYCLES - 1)) begin
                lvl_nxt = sync_r[g];
                cnt_nxt = 8'h00;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
        always_ff @(posedge CLK_SYS_IN) begin
            if (RST_IN) begin
                cnt_r <= 8'h00;
                lvl_r <= 1'b1;
            end else begin
                cnt_r <= cnt_nxt;
                lvl_r <= lvl_nxt;
            end
        end
        assign line_f[g] = lvl_r;
    end

    logic [1:0] line_d_r;
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            line_d_r <= 2'h3;
        end else begin
            line_d_r <= line_f;
        end
    end
    logic scl_f, sda_f, scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_f = line_f[0];
    assign sda_f = line_f[1];
    assign scl_rise = scl_f & ~line_d_r[0];
    assign scl_fall = ~scl_f & line_d_r[0];
    assign bus_start = scl_f & line_d_r[0] & line_d_r[1] & ~sda_f;
    assign bus_stop = scl_f & line_d_r[0] & ~line_d_r[1] & sda_f;

    // ----------------------------------------------------------------
    // two-entry write buffer
    // ----------------------------------------------------------------
    eeprom_front_pkg::wr_item_type fifo_r [FIFO_DEPTH];
    eeprom_front_pkg::wr_item_type push_item, pop_item;
    logic [FPW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [FCW-1:0] fcnt_r, fcnt_nxt;
    logic push_req, push, pop, in_ready, out_valid, out_ready, busy_r;
    assign in_ready = fcnt_r != FCW'(FIFO_DEPTH);
    assign out_valid = fcnt_r != '0;
    assign out_ready = ~busy_r;
    assign push = push_req & in_ready;
    assign pop = out_valid & out_ready;
    assign pop_item = fifo_r[rptr_r];
    always_comb begin
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        fcnt_nxt = fcnt_r;
        if (push) begin
            wptr_nxt = (wptr_r == FPW'(FIFO_DEPTH - 1)) ? '0 : wptr_r + FPW'(1);
        end
        if (pop) begin
            rptr_nxt = (rptr_r == FPW'(FIFO_DEPTH - 1)) ? '0 : rptr_r + FPW'(1);
        end
        if (push && !pop) begin
            fcnt_nxt = fcnt_r + FCW'(1);
        end else if (pop && !push) begin
            fcnt_nxt = fcnt_r - FCW'(1);
        end
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            wptr_r <= '0;
            rptr_r <= '0;
            fcnt_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            fcnt_r <= fcnt_nxt;
        end
        if (push) begin
            fifo_r[wptr_r] <= push_item;
        end
    end

    // ----------------------------------------------------------------
    // link state machine, page latch and programming timer
    // ----------------------------------------------------------------
    logic [7:0] mem_r [eeprom_front_pkg::MEM_DEPTH];
    logic [7:0] page_data_r [eeprom_front_pkg::PAGE_BYTES];
    eeprom_front_pkg::link_state_type state_r, state_nxt;
    eeprom_front_pkg::byte_kind_type kind_r, kind_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shreg_r, shreg_nxt, tx_r, tx_nxt, addr_r, addr_nxt, rx_byte, rd_byte;
    logic [7:0] page_valid_r, page_valid_nxt;
    logic [4:0] page_base_r, page_base_nxt;
    logic ack_ok_r, ack_ok_nxt, rw_r, rw_nxt, drive_r, drive_nxt;
    logic pend_r, pend_nxt, busy_nxt, commit;
    logic [PCW-1:0] prog_cnt_r, prog_cnt_nxt;
    assign rx_byte = {shreg_r[6:0], sda_f};
    assign rd_byte = mem_r[addr_r];

    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        page_valid_nxt = page_valid_r;
        page_base_nxt = page_base_r;
        ack_ok_nxt = ack_ok_r;
        rw_nxt = rw_r;
        drive_nxt = drive_r;
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        prog_cnt_nxt = prog_cnt_r;
        push_req = 1'b0;
        commit = 1'b0;
        // guarded bytes still go through, marked not to be kept
        push_item = '{offset: addr_r[2:0],
                      keep: ~(guard & addr_r[eeprom_front_pkg::GUARD_ADDR_BIT]),
                      data: rx_byte};
        if (pop && pop_item.keep) begin
            page_valid_nxt[pop_item.offset] = 1'b1;
        end
        if (bus_start) begin
            state_nxt = eeprom_front_pkg::ST_RX;
            kind_nxt = eeprom_front_pkg::KIND_DEV;
            cnt_nxt = 4'h0;
            drive_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = eeprom_front_pkg::ST_IDLE;
            drive_nxt = 1'b0;
            pend_nxt = 1'b1;
        end else begin
            unique case (state_r)
                eeprom_front_pkg::ST_IDLE: begin
                end
                eeprom_front_pkg::ST_RX: begin
                    if (scl_rise && cnt_r != eeprom_front_pkg::BIT_DONE) begin
                        shreg_nxt = rx_byte;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == eeprom_front_pkg::BIT_LAST) begin
                            unique case (kind_r)
                                eeprom_front_pkg::KIND_DEV: begin
                                    ack_ok_nxt = rx_byte[7:4] == eeprom_front_pkg::CTRL_CODE
                                        && rx_byte[3:1] == strap && !busy_r;
                                    rw_nxt = rx_byte[0];
                                end
                                eeprom_front_pkg::KIND_WORD: begin
                                    ack_ok_nxt = 1'b1;
                                    addr_nxt = rx_byte;
                                    page_base_nxt = rx_byte[7:3];
                                    page_valid_nxt = 8'h00;
                                end
                                default: begin
                                    push_req = 1'b1;
                                    ack_ok_nxt = in_ready;
                                    if (in_ready) begin
                                        addr_nxt = {addr_r[7:3], addr_r[2:0] + 3'h1};
                                    end
                                end
                            endcase
                        end
                    end else if (scl_fall && cnt_r == eeprom_front_pkg::BIT_DONE) begin
                        state_nxt = ack_ok_r ? eeprom_front_pkg::ST_ACK
                                             : eeprom_front_pkg::ST_IDLE;
                        drive_nxt = ack_ok_r;
                    end
                end
                eeprom_front_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        drive_nxt = 1'b0;
                        if (kind_r == eeprom_front_pkg::KIND_DEV && rw_r) begin
                            state_nxt = eeprom_front_pkg::ST_TX;
                            tx_nxt = rd_byte;
                            drive_nxt = ~rd_byte[7];
                        end else begin
                            state_nxt = eeprom_front_pkg::ST_RX;
                            kind_nxt = (kind_r == eeprom_front_pkg::KIND_DEV)
                                ? eeprom_front_pkg::KIND_WORD : eeprom_front_pkg::KIND_DATA;
                        end
                    end
                end
                eeprom_front_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == eeprom_front_pkg::BIT_LAST) begin
                            state_nxt = eeprom_front_pkg::ST_RACK;
                            drive_nxt = 1'b0;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            drive_nxt = ~tx_r[6];
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                eeprom_front_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_f) begin
                            state_nxt = eeprom_front_pkg::ST_IDLE;
                        end else begin
                            addr_nxt = addr_r + 8'h01;
                        end
                    end else if (scl_fall) begin
                        state_nxt = eeprom_front_pkg::ST_TX;
                        cnt_nxt = 4'h0;
                        tx_nxt = rd_byte;
                        drive_nxt = ~rd_byte[7];
                    end
                end
                default: begin
                    state_nxt = eeprom_front_pkg::ST_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
        if (pend_r && !out_valid) begin
            pend_nxt = bus_stop;
            if (page_valid_r != 8'h00) begin
                busy_nxt = 1'b1;
                prog_cnt_nxt = '0;
            end
        end
        if (busy_r) begin
            prog_cnt_nxt = prog_cnt_r + PCW'(1);
            if (prog_cnt_r == PCW'(PROG_CYCLES - 1)) begin
                busy_nxt = 1'b0;
                commit = 1'b1;
                page_valid_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            state_r <= eeprom_front_pkg::ST_IDLE;
            kind_r <= eeprom_front_pkg::KIND_DEV;
            cnt_r <= 4'h0;
            shreg_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= 8'h00;
            page_valid_r <= 8'h00;
            page_base_r <= 5'h00;
            ack_ok_r <= 1'b0;
            rw_r <= 1'b0;
            drive_r <= 1'b0;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            prog_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            page_valid_r <= page_valid_nxt;
            page_base_r <= page_base_nxt;
            ack_ok_r <= ack_ok_nxt;
            rw_r <= rw_nxt;
            drive_r <= drive_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            prog_cnt_r <= prog_cnt_nxt;
        end
    end

    // array and page latch, no reset: contents are non-volatile
    always_ff @(posedge CLK_SYS_IN) begin
        if (pop && pop_item.keep) begin
            page_data_r[pop_item.offset] <= pop_item.data;
        end
        if (commit) begin
            for (int i = 0; i < eeprom_front_pkg::PAGE_BYTES; i++) begin
                if (page_valid_r[i]) begin
                    mem_r[{page_base_r, 3'(i)}] <= page_data_r[i];
                end
            end
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = drive_r;
    assign BUSY_OUT = busy_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_open_drain_low: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        SDA_OE_OUT |-> SDA_OUT == 1'b0) else $error("data line driven high");
    a_drive_after_fall: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        $changed(SDA_OE_OUT) |-> $past(scl_fall) || $past(bus_start) || $past(bus_stop))
        else $error("data output changed off a falling clock edge");
    a_sample_on_rise: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        state_r == eeprom_front_pkg::ST_RX && cnt_r < 4'h8 && scl_rise && !bus_start
        && !bus_stop |=> cnt_r == $past(cnt_r) + 4'h1 && shreg_r[0] == $past(sda_f))
        else $error("bit not taken on rising clock");
    a_busy_no_ack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        state_r == eeprom_front_pkg::ST_ACK && kind_r == eeprom_front_pkg::KIND_DEV
        |-> !busy_r && shreg_r[7:1] == {eeprom_front_pkg::CTRL_CODE, strap})
        else $error("address acknowledged while programming");
    a_prog_end: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        busy_r && prog_cnt_r == PCW'(PROG_CYCLES - 1) |=> !busy_r && page_valid_r == 8'h00)
        else $error("programming cycle length wrong");
    a_prog_start: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        $rose(busy_r) |-> prog_cnt_r == '0 ##1 prog_cnt_r == PCW'(1))
        else $error("programming timer did not start");
    a_guard_drop: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        push && guard && addr_r[7] |=> ##1 page_valid_r == $past(page_valid_r))
        else $error("guarded byte entered the page");
    a_page_wrap: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        push |=> addr_r[7:3] == $past(addr_r[7:3]) && addr_r[2:0] == $past(addr_r[2:0]) + 3'h1)
        else $error("page address left its page");
    a_full_nack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        push_req && !in_ready |=> !ack_ok_r) else $error("byte acknowledged while buffer full");
    a_seq_read: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        state_r == eeprom_front_pkg::ST_RACK && scl_rise && !sda_f && !bus_start && !bus_stop
        |=> addr_r == $past(addr_r) + 8'h01) else $error("sequential read did not advance");
endmodule : eeprom_twowire_front
